// ==== verilog/lcc_top.sv ====
// Logic cell control, status, output mirror and interrupt block
//
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "lcc_consts.svh"
module lcc_top #(
	parameter int N_CELLS = 2
) (
	// Clock and reset
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// AXI4-Lite write address and data
	input  wire logic [`LCC_ADDR_W-1:0] s_axil_awaddr,
	input  wire logic                  s_axil_awvalid,
	output logic                       s_axil_awready,
	input  wire logic [31:0]           s_axil_wdata,
	input  wire logic [3:0]            s_axil_wstrb,
	input  wire logic                  s_axil_wvalid,
	output logic                       s_axil_wready,
	// AXI4-Lite write response
	output logic [1:0]                 s_axil_bresp,
	output logic                       s_axil_bvalid,
	input  wire logic                  s_axil_bready,
	// AXI4-Lite read
	input  wire logic [`LCC_ADDR_W-1:0] s_axil_araddr,
	input  wire logic                  s_axil_arvalid,
	output logic                       s_axil_arready,
	output logic [31:0]                s_axil_rdata,
	output logic [1:0]                 s_axil_rresp,
	output logic                       s_axil_rvalid,
	input  wire logic                  s_axil_rready,
	// Gate outputs from the gating stage, four per cell
	input  wire logic [4*N_CELLS-1:0]  gate_in,
	// Sleep handling
	input  wire logic                  sleep_mode,
	input  wire logic [N_CELLS-1:0]    fast_osc_selected,
	output logic                       fast_internal_osc_keep,
	// Cell outputs and pins
	output logic [N_CELLS-1:0]         cell_out,
	output logic [N_CELLS-1:0]         pin_out,
	output logic [N_CELLS-1:0]         pin_oe,
	// Interrupt
	output logic                       irq
);
	// Register strobes from the bus front end
	logic                   wr_en;
	logic [`LCC_ADDR_W-1:0] wr_addr;
	logic [31:0]            wr_data;
	logic [3:0]             wr_strb;
	logic                   wr_ok;
	logic                   rd_en;
	logic [`LCC_ADDR_W-1:0] rd_addr;
	logic [31:0]            rd_data;
	logic                   rd_ok;

	// Register state
	logic [7:0]             ctrl_q [N_CELLS];
	logic [N_CELLS-1:0]     pol_q;
	logic [N_CELLS-1:0]     stat_q;
	logic [N_CELLS-1:0]     stat_d;
	logic [N_CELLS-1:0]     mask_q;

	// Per-cell wiring
	logic [N_CELLS-1:0]     en_vec;
	logic [N_CELLS-1:0]     oe_vec;
	logic [N_CELLS-1:0]     rise_ev;
	logic [N_CELLS-1:0]     fall_ev;
	logic [N_CELLS-1:0]     irq_set;
	logic [N_CELLS-1:0]     irq_clr;
	logic [7:0]             ctrl_rd [N_CELLS];

	// Decode wires
	logic                   wr_is_ctrl;
	logic                   wr_is_pol;
	logic                   wr_is_mask;
	logic                   rd_is_ctrl;
	logic                   rd_is_pol;
	logic                   rd_is_mirr;
	logic                   rd_is_stat;
	logic                   rd_is_mask;
	logic [1:0]             wr_idx;
	logic [1:0]             rd_idx;
	logic [7:0]             ctrl_sel;
	logic [31:0]            pad_cells;

	// Base as a named value, so its upper nibble can be selected
	localparam logic [`LCC_ADDR_W-1:0] ctrl_base = `LCC_CTRL_BASE;

	// Refuse cell counts the register map cannot hold
	if (N_CELLS < 1 || N_CELLS > `LCC_MAX_CELLS) begin : g_bad_cells
		$error("lcc_top: N_CELLS must be 1 to 4");
	end

	// Bus front end
	lcc_axil u_axil (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awaddr  (s_axil_awaddr),
		.awvalid (s_axil_awvalid),
		.awready (s_axil_awready),
		.wdata   (s_axil_wdata),
		.wstrb   (s_axil_wstrb),
		.wvalid  (s_axil_wvalid),
		.wready  (s_axil_wready),
		.bresp   (s_axil_bresp),
		.bvalid  (s_axil_bvalid),
		.bready  (s_axil_bready),
		.araddr  (s_axil_araddr),
		.arvalid (s_axil_arvalid),
		.arready (s_axil_arready),
		.rdata   (s_axil_rdata),
		.rresp   (s_axil_rresp),
		.rvalid  (s_axil_rvalid),
		.rready  (s_axil_rready),
		.wr_en   (wr_en),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.wr_strb (wr_strb),
		.wr_ok   (wr_ok),
		.rd_en   (rd_en),
		.rd_addr (rd_addr),
		.rd_data (rd_data),
		.rd_ok   (rd_ok)
	);

	// Write decode; control words sit one per cell from the base
	assign wr_idx     = wr_addr[3:2];
	assign wr_is_ctrl = (wr_addr[`LCC_ADDR_W-1:4] == ctrl_base[`LCC_ADDR_W-1:4])
		&& (wr_addr[1:0] == 2'h0) && (32'(wr_idx) < N_CELLS);
	assign wr_is_pol  = (wr_addr == `LCC_POL_ADDR);
	assign wr_is_mask = (wr_addr == `LCC_MASK_ADDR);
	// Mirror and status are read-only; writes to them are accepted and dropped
	assign wr_ok      = wr_is_ctrl | wr_is_pol | wr_is_mask
		| (wr_addr == `LCC_MIRR_ADDR) | (wr_addr == `LCC_STAT_ADDR);

	// Read decode
	assign rd_idx     = rd_addr[3:2];
	assign rd_is_ctrl = (rd_addr[`LCC_ADDR_W-1:4] == ctrl_base[`LCC_ADDR_W-1:4])
		&& (rd_addr[1:0] == 2'h0) && (32'(rd_idx) < N_CELLS);
	assign rd_is_pol  = (rd_addr == `LCC_POL_ADDR);
	assign rd_is_mirr = (rd_addr == `LCC_MIRR_ADDR);
	assign rd_is_stat = (rd_addr == `LCC_STAT_ADDR);
	assign rd_is_mask = (rd_addr == `LCC_MASK_ADDR);
	assign rd_ok      = rd_is_ctrl | rd_is_pol | rd_is_mirr | rd_is_stat | rd_is_mask;

	// Per-cell control register, function stage and pin drive
	for (genvar i = 0; i < N_CELLS; i++) begin : g_cell
		logic wr_hit;
		assign wr_hit = wr_en & wr_is_ctrl & wr_strb[0] & (32'(wr_idx) == i);

		// Cleared on every reset; output value bit is never stored
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				ctrl_q[i] <= `LCC_CTRL_RST;
			end else if (wr_hit) begin
				ctrl_q[i] <= wr_data[7:0] & `LCC_CTRL_WMASK;
			end
		end

		assign en_vec[i] = ctrl_q[i][`LCC_EN_BIT];
		assign oe_vec[i] = ctrl_q[i][`LCC_OE_BIT];

		// Runs on aclk, which stays live in sleep; no sleep gating here
		lcc_cell u_cell (
			.aclk            (aclk),
			.aresetn         (aresetn),
			.cell_enable     (en_vec[i]),
			.output_invert   (pol_q[i]),
			.function_select (ctrl_q[i][`LCC_FUNC_MSB:`LCC_FUNC_LSB]),
			.gate            (gate_in[4*i +: 4]),
			.cell_out        (cell_out[i]),
			.rise_pulse      (rise_ev[i]),
			.fall_pulse      (fall_ev[i])
		);

		// Read view puts the live output into its read-only slot
		always_comb begin
			ctrl_rd[i]               = ctrl_q[i];
			ctrl_rd[i][`LCC_OUT_BIT] = cell_out[i];
		end

		// Edge qualified by its own enable sets the flag
		assign irq_set[i] = (rise_ev[i] & ctrl_q[i][`LCC_RISE_BIT])
			| (fall_ev[i] & ctrl_q[i][`LCC_FALL_BIT]);

		// Pin follows the cell only while its output enable is set
		assign pin_out[i] = oe_vec[i] & cell_out[i];
		assign pin_oe[i]  = oe_vec[i];
	end

	// Polarity register; not part of the control word, but cleared on reset too
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pol_q <= N_CELLS'(`LCC_POL_RST);
		end else if (wr_en && wr_is_pol && wr_strb[0]) begin
			pol_q <= wr_data[N_CELLS-1:0];
		end
	end

	// Mask register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mask_q <= N_CELLS'(`LCC_MASK_RST);
		end else if (wr_en && wr_is_mask && wr_strb[0]) begin
			mask_q <= wr_data[N_CELLS-1:0];
		end
	end

	// Sticky flags; a read clears them, but a same-cycle edge wins
	assign irq_clr = (rd_en && rd_is_stat) ? stat_q : '0;
	assign stat_d  = (stat_q & ~irq_clr) | irq_set;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stat_q <= N_CELLS'(`LCC_STAT_RST);
		end else begin
			stat_q <= stat_d;
		end
	end

	assign irq = |(stat_q & mask_q);

	// Read mux; the front end latches it, so the mirror is one snapshot
	// Index folded into range; an unmapped slot is masked by the decode anyway
	assign ctrl_sel  = ctrl_rd[32'(rd_idx) % N_CELLS];
	assign pad_cells = 32'(cell_out);
	assign rd_data   = rd_is_ctrl ? {24'h00_0000, ctrl_sel}
		: rd_is_mirr ? pad_cells
		: rd_is_pol  ? 32'(pol_q)
		: rd_is_stat ? 32'(stat_q)
		: rd_is_mask ? 32'(mask_q)
		: 32'h0000_0000;

	// Keep fast oscillator alive in sleep while an enabled cell uses it
	assign fast_internal_osc_keep = sleep_mode
		& |(en_vec & fast_osc_selected);
endmodule : lcc_top

// ==== verilog/lcc_consts.svh ====
// Register offsets, field positions, reset values and bus codes of the logic cell block
`ifndef LCC_CONSTS_SVH
`define LCC_CONSTS_SVH
`define LCC_ADDR_W     8
`define LCC_CTRL_BASE  8'h00
`define LCC_POL_ADDR   8'h10
`define LCC_MIRR_ADDR  8'h14
`define LCC_STAT_ADDR  8'h18
`define LCC_MASK_ADDR  8'h1c
`define LCC_MAX_CELLS  4
`define LCC_EN_BIT     7
`define LCC_OE_BIT     6
`define LCC_OUT_BIT    5
`define LCC_RISE_BIT   4
`define LCC_FALL_BIT   3
`define LCC_FUNC_MSB   2
`define LCC_FUNC_LSB   0
`define LCC_CTRL_WMASK 8'hdf
`define LCC_CTRL_RST   8'h00
`define LCC_POL_RST    8'h00
`define LCC_MASK_RST   8'h00
`define LCC_STAT_RST   8'h00
`define LCC_RESP_OKAY  2'h0
`define LCC_RESP_SLV   2'h2
`endif

// ==== verilog/lcc_pkg.sv ====
// Types shared by the logic cell block
package lcc_pkg;
	typedef enum logic [2:0] {
		LCC_AND_OR  = 3'h0,
		LCC_OR_XOR  = 3'h1,
		LCC_AND4    = 3'h2,
		LCC_SR_LAT  = 3'h3,
		LCC_DFF_SR  = 3'h4,
		LCC_DFF_R   = 3'h5,
		LCC_JK_R    = 3'h6,
		LCC_TLAT_SR = 3'h7
	} lcc_func_t;
endpackage : lcc_pkg

// ==== verilog/lcc_cell.sv ====
// One logic cell: function stage, output inversion, enable and edge detection
`timescale 1ns/1ps
module lcc_cell (
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Configuration
	input  wire logic       cell_enable,
	input  wire logic       output_invert,
	input  wire logic [2:0] function_select,
	// Gate outputs from the gating stage
	input  wire logic [3:0] gate,
	// Cell output and edge pulses
	output logic            cell_out,
	output logic            rise_pulse,
	output logic            fall_pulse
);
	logic  q_q;
	logic  q_d;
	logic  clk_prev_q;
	logic  out_q;
	logic  out_d;
	logic  comb_val;
	logic  lf_val;
	logic  tick;
	wire   g1 = gate[0];
	wire   g2 = gate[1];
	wire   g3 = gate[2];
	wire   g4 = gate[3];
	lcc_pkg::lcc_func_t fsel;

	// Gate 1 acts as the storage clock; its rise is found against aclk
	assign fsel = lcc_pkg::lcc_func_t'(function_select);
	assign tick = g1 & ~clk_prev_q;

	// Eight logic functions; storage ones hold their bit in q_q
	always_comb begin
		q_d      = q_q;
		comb_val = 1'b0;
		unique case (fsel)
			lcc_pkg::LCC_AND_OR:  comb_val = (g1 & g2) | (g3 & g4);
			lcc_pkg::LCC_OR_XOR:  comb_val = (g1 | g2) ^ (g3 | g4);
			lcc_pkg::LCC_AND4:    comb_val = g1 & g2 & g3 & g4;
			lcc_pkg::LCC_SR_LAT:  q_d = (g1 | g2) ? 1'b1 : ((g3 | g4) ? 1'b0 : q_q);
			lcc_pkg::LCC_DFF_SR:  q_d = g4 ? 1'b1 : (g3 ? 1'b0 : (tick ? g2 : q_q));
			lcc_pkg::LCC_DFF_R:   q_d = g3 ? 1'b0 : (tick ? (g2 | g4) : q_q);
			lcc_pkg::LCC_JK_R:    q_d = g3 ? 1'b0 : (tick ? ((g2 & ~q_q) | (~g4 & q_q)) : q_q);
			lcc_pkg::LCC_TLAT_SR: q_d = g4 ? 1'b1 : (g3 ? 1'b0 : (g1 ? g2 : q_q));
		endcase
	end

	// Combinational functions pass straight, storage functions show the next stored bit q_d
	assign lf_val = fsel inside {lcc_pkg::LCC_AND_OR, lcc_pkg::LCC_OR_XOR,
		lcc_pkg::LCC_AND4} ? comb_val : q_d;
	// Disabled cell drives zero; inversion applied after logic stage
	assign out_d = cell_enable ? (lf_val ^ output_invert) : 1'b0;

	// Storage and output flops; a disabled cell also drops its stored bit
	always_ff @(posedge aclk) begin
		if (!aresetn || !cell_enable) begin
			q_q        <= 1'b0;
			clk_prev_q <= 1'b0;
		end else begin
			q_q        <= q_d;
			clk_prev_q <= g1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_q <= 1'b0;
		end else begin
			out_q <= out_d;
		end
	end

	// Edge detectors on the final output, so polarity flips count too
	assign cell_out   = out_q;
	assign rise_pulse = out_d & ~out_q;
	assign fall_pulse = ~out_d & out_q;
endmodule : lcc_cell

// ==== verilog/lcc_axil.sv ====
// AXI4-Lite slave front end that turns bus traffic into register strobes
`timescale 1ns/1ps
`include "lcc_consts.svh"
module lcc_axil (
	// Clock and reset
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// Write address and data
	input  wire logic [`LCC_ADDR_W-1:0] awaddr,
	input  wire logic                  awvalid,
	output logic                       awready,
	input  wire logic [31:0]           wdata,
	input  wire logic [3:0]            wstrb,
	input  wire logic                  wvalid,
	output logic                       wready,
	// Write response
	output logic [1:0]                 bresp,
	output logic                       bvalid,
	input  wire logic                  bready,
	// Read address and data
	input  wire logic [`LCC_ADDR_W-1:0] araddr,
	input  wire logic                  arvalid,
	output logic                       arready,
	output logic [31:0]                rdata,
	output logic [1:0]                 rresp,
	output logic                       rvalid,
	input  wire logic                  rready,
	// Register side
	output logic                       wr_en,
	output logic [`LCC_ADDR_W-1:0]     wr_addr,
	output logic [31:0]                wr_data,
	output logic [3:0]                 wr_strb,
	input  wire logic                  wr_ok,
	output logic                       rd_en,
	output logic [`LCC_ADDR_W-1:0]     rd_addr,
	input  wire logic [31:0]           rd_data,
	input  wire logic                  rd_ok
);
	logic aw_have_q;
	logic w_have_q;
	logic aw_take;
	logic w_take;

	// Address and data may arrive in either order; each is held once taken
	assign awready = ~aw_have_q & ~bvalid;
	assign wready  = ~w_have_q & ~bvalid;
	assign aw_take = awvalid & awready;
	assign w_take  = wvalid & wready;
	assign wr_en   = aw_have_q & w_have_q & ~bvalid;
	assign arready = ~rvalid;
	assign rd_en   = arvalid & arready;
	assign rd_addr = araddr;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			wr_addr   <= '0;
			wr_data   <= 32'h0000_0000;
			wr_strb   <= 4'h0;
		end else begin
			if (aw_take) begin
				aw_have_q <= 1'b1;
				wr_addr   <= awaddr;
			end else if (wr_en) begin
				aw_have_q <= 1'b0;
			end
			if (w_take) begin
				w_have_q <= 1'b1;
				wr_data  <= wdata;
				wr_strb  <= wstrb;
			end else if (wr_en) begin
				w_have_q <= 1'b0;
			end
		end
	end

	// Response flops; read data caught at the address edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= `LCC_RESP_OKAY;
			rvalid <= 1'b0;
			rresp  <= `LCC_RESP_OKAY;
			rdata  <= 32'h0000_0000;
		end else begin
			if (wr_en) begin
				bvalid <= 1'b1;
				bresp  <= wr_ok ? `LCC_RESP_OKAY : `LCC_RESP_SLV;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
			if (rd_en) begin
				rvalid <= 1'b1;
				rdata  <= rd_data;
				rresp  <= rd_ok ? `LCC_RESP_OKAY : `LCC_RESP_SLV;
			end else if (rready) begin
				rvalid <= 1'b0;
			end
		end
	end
endmodule : lcc_axil

// ==== sim/lcc_checker.sv ====
// Port-level assertions of the logic cell block
`timescale 1ns/1ps
`include "lcc_consts.svh"
module lcc_checker #(
	parameter int N_CELLS = 2
) (
	// Clock and reset
	input wire logic                    aclk,
	input wire logic                    aresetn,
	// Bus handshakes
	input wire logic                    s_axil_awvalid,
	input wire logic                    s_axil_awready,
	input wire logic                    s_axil_wvalid,
	input wire logic                    s_axil_wready,
	input wire logic                    s_axil_bvalid,
	input wire logic                    s_axil_bready,
	input wire logic [`LCC_ADDR_W-1:0]  s_axil_araddr,
	input wire logic                    s_axil_arvalid,
	input wire logic                    s_axil_arready,
	input wire logic [31:0]             s_axil_rdata,
	input wire logic                    s_axil_rvalid,
	input wire logic                    s_axil_rready,
	// Sleep and cell side
	input wire logic                    sleep_mode,
	input wire logic [N_CELLS-1:0]      fast_osc_selected,
	input wire logic                    fast_internal_osc_keep,
	input wire logic [N_CELLS-1:0]      cell_out,
	input wire logic [N_CELLS-1:0]      pin_out,
	input wire logic [N_CELLS-1:0]      pin_oe,
	input wire logic                    irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Bus steps
	sequence s_wr; s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready; endsequence
	sequence s_ar; s_axil_arvalid && s_axil_arready; endsequence
	property p_wr_lat; s_wr |-> ##2 s_axil_bvalid; endproperty
	property p_b_hold; s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid; endproperty
	property p_r_lat; s_ar |=> s_axil_rvalid; endproperty
	property p_r_hold; s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid && $stable(s_axil_rdata);
	endproperty
	property p_ar_blk; s_axil_rvalid |-> !s_axil_arready; endproperty
	// One read shows all outputs of a single edge
	property p_mirr; s_ar ##0 (s_axil_araddr == `LCC_MIRR_ADDR) |=>
		s_axil_rdata == {{(32-N_CELLS){1'b0}}, $past(cell_out)}; endproperty
	property p_pin; pin_out == (cell_out & pin_oe); endproperty
	property p_keep; fast_internal_osc_keep |-> sleep_mode && (|fast_osc_selected); endproperty
	property p_rst; $rose(aresetn) |-> cell_out == '0 && pin_oe == '0 && !irq; endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
	a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
	a_r_lat: assert property (p_r_lat) else $error("read answer late");
	a_r_hold: assert property (p_r_hold) else $error("read data not held");
	a_ar_blk: assert property (p_ar_blk) else $error("read taken while answer pending");
	a_mirr: assert property (p_mirr) else $error("mirror value skewed");
	a_pin: assert property (p_pin) else $error("pin drive wrong");
	a_keep: assert property (p_keep) else $error("oscillator kept wrongly");
	a_rst: assert property (p_rst) else $error("reset left state");
endmodule : lcc_checker
bind lcc_top lcc_checker #(.N_CELLS(N_CELLS)) lcc_checker_i (.aclk(aclk), .aresetn(aresetn),
	.s_axil_awvalid(s_axil_awvalid), .s_axil_awready(s_axil_awready),
	.s_axil_wvalid(s_axil_wvalid), .s_axil_wready(s_axil_wready),
	.s_axil_bvalid(s_axil_bvalid), .s_axil_bready(s_axil_bready),
	.s_axil_araddr(s_axil_araddr), .s_axil_arvalid(s_axil_arvalid),
	.s_axil_arready(s_axil_arready), .s_axil_rdata(s_axil_rdata),
	.s_axil_rvalid(s_axil_rvalid), .s_axil_rready(s_axil_rready), .sleep_mode(sleep_mode),
	.fast_osc_selected(fast_osc_selected), .fast_internal_osc_keep(fast_internal_osc_keep),
	.cell_out(cell_out), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));

// ==== sim/logic_cell_control_status_tb_top.sv ====
// Self-checking bench of the logic cell block
`timescale 1ns/1ps
`include "lcc_consts.svh"
module logic_cell_control_status_tb_top;
	localparam logic [7:0] ctl = `LCC_CTRL_BASE;
	localparam logic [7:0] pol = `LCC_POL_ADDR;
	localparam logic [7:0] mir = `LCC_MIRR_ADDR;
	localparam logic [7:0] sta = `LCC_STAT_ADDR;
	localparam logic [7:0] msk = `LCC_MASK_ADDR;
	localparam logic [1:0] ok  = `LCC_RESP_OKAY;
	logic       aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
	logic       arvalid = 0, rready = 0, sleep_mode = 0;
	logic [7:0] awaddr = 0, araddr = 0, gate_in = 0, seed = 8'h35;
	logic [31:0] wdata = 0, v;
	logic [3:0] wstrb = 0, ws = 4'hf;
	logic [2:0] f0, f1;
	logic       q, g1;
	logic [1:0] fast_osc_selected = 0, inv, en, ex;
	wire logic        awready, wready, bvalid, arready, rvalid, keep, irq;
	wire logic [1:0]  bresp, rresp, cell_out, pin_out, pin_oe;
	wire logic [31:0] rdata;
	int         n_mismatch = 0, checks = 0, cyc = 0;

	lcc_top #(.N_CELLS(2)) lcc_top_i (.aclk(aclk), .aresetn(aresetn), .s_axil_awaddr(awaddr),
		.s_axil_awvalid(awvalid), .s_axil_awready(awready), .s_axil_wdata(wdata),
		.s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid), .s_axil_wready(wready),
		.s_axil_bresp(bresp), .s_axil_bvalid(bvalid), .s_axil_bready(bready),
		.s_axil_araddr(araddr), .s_axil_arvalid(arvalid), .s_axil_arready(arready),
		.s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid),
		.s_axil_rready(rready), .gate_in(gate_in), .sleep_mode(sleep_mode),
		.fast_osc_selected(fast_osc_selected), .fast_internal_osc_keep(keep),
		.cell_out(cell_out), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));

	// Clock and hang guard
	always #12.5 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			results();
		end
	end
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	// Expected output of the combinational functions only
	function automatic logic cf(input logic [2:0] f, input logic [3:0] g);
		case (f)
			3'h0: return (g[0] & g[1]) | (g[2] & g[3]);
			3'h1: return (g[0] | g[1]) ^ (g[2] | g[3]);
			default: return &g;
		endcase
	endfunction : cf
	// Next stored bit of the storage functions; t is a rise of gate 1
	function automatic logic sf(input logic [2:0] f, input logic [3:0] g, input logic q,
		input logic t);
		case (f)
			3'h3: return (g[0] | g[1]) ? 1'b1 : ((g[2] | g[3]) ? 1'b0 : q);
			3'h4: return g[3] ? 1'b1 : (g[2] ? 1'b0 : (t ? g[1] : q));
			3'h5: return g[2] ? 1'b0 : (t ? (g[1] | g[3]) : q);
			3'h6: return g[2] ? 1'b0 : (t ? ((g[1] & ~q) | (~g[3] & q)) : q);
			default: return g[3] ? 1'b1 : (g[2] ? 1'b0 : (g[0] ? g[1] : q));
		endcase
	endfunction : sf
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	// Address and data offered together, each dropped once taken
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_d, w_d;
		aw_d = 0;
		w_d = 0;
		awaddr <= a;
		wdata <= d;
		wstrb <= ws;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!(aw_d && w_d)) begin
			@(posedge aclk);
			if (!aw_d && awready === 1'b1) begin
				aw_d = 1;
				awvalid <= 0;
			end
			if (!w_d && wready === 1'b1) begin
				w_d = 1;
				wvalid <= 0;
			end
		end
		while (bvalid !== 1'b1) @(posedge aclk);
		chk(32'(bresp), 32'(er));
		bready <= 0;
		@(posedge aclk);
	endtask : wr
	task rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		@(posedge aclk);
		while (arready !== 1'b1) @(posedge aclk);
		arvalid <= 0;
		@(posedge aclk);
		while (rvalid !== 1'b1) @(posedge aclk);
		d = rdata;
		chk(32'(rresp), 32'(er));
		rready <= 0;
		@(posedge aclk);
	endtask : rd
	task rc(input logic [7:0] a, input logic [31:0] exp);
		rd(a, ok, v);
		chk(v, exp);
	endtask : rc
	// One interrupt step: mask, control, invert, then gates
	task ev(input logic [7:0] c, input logic p, input logic [7:0] g, input logic m, input logic e);
		wr(msk, 32'(m), ok);
		wr(ctl, 32'(c), ok);
		wr(pol, 32'(p), ok);
		gate_in <= g;
		repeat (3) @(posedge aclk);
		chk(32'(irq), 32'(e & m));
		rc(sta, 32'(e));
		chk(32'(irq), 32'h0);
	endtask : ev
	task results();
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : results

	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		// Reset values and an unmapped slot
		rc(ctl, 32'h0);
		rc(ctl + 8'h04, 32'h0);
		rc(sta, 32'h0);
		rc(msk, 32'h0);
		rd(ctl + 8'h08, `LCC_RESP_SLV, v);
		chk(v, 32'h0);
		wr(ctl + 8'h08, 32'hff, `LCC_RESP_SLV);
		// Every function code with the cell off; output bit is read-only
		for (int f = 0; f < 8; f++) begin
			wr(ctl, 32'h78 | f, ok);
			rc(ctl, 32'h58 | f);
			chk(32'(pin_oe[0]), 32'h1);
			chk(32'(cell_out[0]), 32'h0);
		end
		// Low byte strobe off leaves the register alone
		ws = 4'he;
		wr(ctl, 32'h0, ok);
		ws = 4'hf;
		rc(ctl, 32'h5f);
		// Random gates, functions, inversion and sleep
		repeat (20) begin
			seed = lfsr(seed);
			f0 = 3'(seed % 3);
			inv = seed[7:6];
			seed = lfsr(seed);
			f1 = 3'(seed % 3);
			en = seed[5:4];
			seed = lfsr(seed);
			gate_in <= seed;
			seed = lfsr(seed);
			sleep_mode <= seed[0];
			fast_osc_selected <= seed[2:1];
			wr(pol, 32'(inv), ok);
			wr(ctl, 32'({en[0], 7'h40} | f0), ok);
			wr(ctl + 8'h04, 32'({en[1], 7'h00} | f1), ok);
			ex[0] = en[0] & (cf(f0, gate_in[3:0]) ^ inv[0]);
			ex[1] = en[1] & (cf(f1, gate_in[7:4]) ^ inv[1]);
			chk(32'(cell_out), 32'(ex));
			chk(32'(pin_out), 32'(ex & 2'h1));
			chk(32'(keep), 32'(sleep_mode & (|(en & fast_osc_selected))));
			rc(mir, 32'(ex));
			rc(ctl, 32'({en[0], 1'b1, ex[0], 5'h00} | f0));
		end
		// Storage functions from a cleared bit; gates settle two edges per step
		wr(pol, 32'h0, ok);
		for (int f = 3; f < 8; f++) begin
			gate_in <= 8'h00;
			wr(ctl, 32'h00, ok);
			wr(ctl, 32'h80 | f, ok);
			q = 1'b0;
			g1 = 1'b0;
			repeat (8) begin
				seed = lfsr(seed);
				gate_in <= seed;
				repeat (2) @(posedge aclk);
				q = sf(3'(f), seed[3:0], q, seed[0] & ~g1);
				g1 = seed[0];
				chk(32'(cell_out[0]), 32'(q));
			end
		end
		// Rise, fall, inversion edge and masking
		gate_in <= 8'h00;
		wr(pol, 32'h0, ok);
		ev(8'h92, 1'b0, 8'hff, 1'b1, 1'b1);
		ev(8'h92, 1'b0, 8'h00, 1'b1, 1'b0);
		ev(8'h8a, 1'b0, 8'hff, 1'b1, 1'b0);
		ev(8'h8a, 1'b0, 8'h00, 1'b1, 1'b1);
		ev(8'h92, 1'b1, 8'h00, 1'b1, 1'b1);
		ev(8'h8a, 1'b0, 8'h00, 1'b0, 1'b1);
		// Flag set by a rise, then a fall lands on the read that clears it
		wr(msk, 32'h1, ok);
		wr(ctl, 32'h9a, ok);
		gate_in <= 8'h0f;
		repeat (2) @(posedge aclk);
		gate_in <= 8'h00;
		rd(sta, ok, v);
		chk(v, 32'h1);
		rc(sta, 32'h1);
		// Reset in mid-run clears control and invert
		wr(pol, 32'h1, ok);
		aresetn <= 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		rc(ctl, 32'h0);
		rc(pol, 32'h0);
		results();
	end
endmodule : logic_cell_control_status_tb_top
